// >>> rtl/rpd_top.sv
// Rotor position detector with AXI4-Lite registers
`default_nettype none
module rpd_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic phase_u_input,
    input wire logic phase_v_input,
    input wire logic phase_w_input,
    input wire logic [2:0] pwm_phase_on,
    input wire logic [2:0] lower_phase_on,
    input wire logic timer2_trigger,
    input wire logic timer3_trigger,
    output logic position_detected,
    output logic position_interrupt
);
    logic [7:0] sampling_setup_reg;
    logic [5:0] control_reg;
    logic [6:0] sampling_delay_reg;
    logic [2:0] motor_output_pattern_reg;
    logic [1:0] pwm_edge_result_reg;
    logic [2:0] captured_input_pattern_reg;
    rpd_pkg::rpd_state_e state_reg;
    logic stop_pending_reg;
    logic armed_reg;
    logic [3:0] hit_cnt_reg;
    logic [4:0] presc_reg;
    logic [6:0] delay_cnt_reg;
    logic pwm_prev_reg;
    logic [2:0] lower_prev_reg;
    logic [2:0] held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_held_reg;
    logic [31:0] wdata_reg;
    logic wstrb0_reg;
    logic w_held_reg;

    logic [1:0] period_sel;
    logic [1:0] sample_mode;
    logic [3:0] match_target;
    logic timer_stop_enable;
    logic timer_start_enable;
    logic one_pin;
    logic per_pulse_recount;
    logic mismatch_mode;
    logic detector_enable;
    logic running;
    logic strobe;
    logic pwm_any;
    logic pwm_rise;
    logic pwm_fall;
    logic delay_done;
    logic blank_start;
    logic [2:0] phase_win;
    logic window;
    logic [2:0] live_in;
    logic [2:0] eff_in;
    logic [2:0] cmp_mask;
    logic match;
    logic differ;
    logic sample_ok;
    logic hit;
    logic fire;
    logic wr_do;
    logic soft_start;
    logic soft_stop;
    logic start_req;
    logic stop_req;

    assign period_sel = sampling_setup_reg[rpd_pkg::SU_PERIOD_LSB +: 2];
    assign sample_mode = sampling_setup_reg[rpd_pkg::SU_MODE_LSB +: 2];
    assign match_target = sampling_setup_reg[rpd_pkg::SU_COUNT_LSB +: 4];
    assign timer_stop_enable = control_reg[rpd_pkg::CT_TSTOP_EN_BIT];
    assign timer_start_enable = control_reg[rpd_pkg::CT_TSTART_EN_BIT];
    assign one_pin = control_reg[rpd_pkg::CT_PIN_COUNT_BIT];
    assign per_pulse_recount = control_reg[rpd_pkg::CT_RECOUNT_BIT];
    assign mismatch_mode = control_reg[rpd_pkg::CT_MISMATCH_BIT];
    assign detector_enable = control_reg[rpd_pkg::CT_ENABLE_BIT];
    assign running = (state_reg == rpd_pkg::RPD_RUN);

    // Strobe every 4, 8, 16 or 32 clocks
    always_comb begin
        unique case (period_sel)
            2'h0: strobe = (presc_reg[1:0] == 2'h3);
            2'h1: strobe = (presc_reg[2:0] == 3'h7);
            2'h2: strobe = (presc_reg[3:0] == 4'hf);
            2'h3: strobe = (presc_reg == 5'h1f);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            presc_reg <= 5'h00;
        end else begin
            presc_reg <= presc_reg + 5'h01;
        end
    end

    assign pwm_any = |pwm_phase_on;
    assign pwm_rise = pwm_any && !pwm_prev_reg;
    assign pwm_fall = !pwm_any && pwm_prev_reg;
    assign blank_start = (sample_mode == rpd_pkg::MODE_PWM_ON && pwm_rise) ||
                         (sample_mode == rpd_pkg::MODE_LOWER &&
                          |(lower_phase_on & ~lower_prev_reg));
    // Onset cycle is blanked too, so exactly the delay is skipped
    assign delay_done = (delay_cnt_reg == 7'h00) &&
                        !(blank_start && sampling_delay_reg != 7'h00);

    // Noise blanking restarts at each conduction onset
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwm_prev_reg <= 1'b0;
            lower_prev_reg <= 3'h0;
            delay_cnt_reg <= 7'h00;
        end else begin
            pwm_prev_reg <= pwm_any;
            lower_prev_reg <= lower_phase_on;
            if (blank_start && sampling_delay_reg != 7'h00) begin
                delay_cnt_reg <= sampling_delay_reg - 7'h01;
            end else if (blank_start) begin
                delay_cnt_reg <= 7'h00;
            end else if (!delay_done) begin
                delay_cnt_reg <= delay_cnt_reg - 7'h01;
            end
        end
    end

    assign live_in = {phase_w_input, phase_v_input, phase_u_input};

    // Each lower phase keeps its last sample while it is off
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_phase
            assign phase_win[gi] = lower_phase_on[gi] && delay_done;
            always_ff @(posedge clk) begin
                if (!resetn) begin
                    held_reg[gi] <= 1'b0;
                end else if (strobe && phase_win[gi]) begin
                    held_reg[gi] <= live_in[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        unique case (sample_mode)
            rpd_pkg::MODE_PWM_ON: window = pwm_any && delay_done;
            rpd_pkg::MODE_LOWER: window = |phase_win;
            default: window = 1'b1;
        endcase
    end

    assign eff_in = (sample_mode == rpd_pkg::MODE_LOWER) ? held_reg : live_in;
    assign cmp_mask = one_pin ? 3'h1 : 3'h7;
    assign match = ((eff_in ^ motor_output_pattern_reg) & cmp_mask) == 3'h0;
    assign differ = ((eff_in ^ captured_input_pattern_reg) & cmp_mask) != 3'h0;
    assign sample_ok = running && strobe && window;
    assign hit = mismatch_mode ? differ : (armed_reg && match);
    assign fire = sample_ok && hit &&
                  (({1'b0, hit_cnt_reg} + 5'h01) >= {1'b0, match_target});

    assign wr_do = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign soft_start = wr_do && wstrb0_reg && awaddr_reg == rpd_pkg::CONTROL_OFS &&
                        wdata_reg[rpd_pkg::CT_SOFT_START_BIT];
    assign soft_stop = wr_do && wstrb0_reg && awaddr_reg == rpd_pkg::CONTROL_OFS &&
                       wdata_reg[rpd_pkg::CT_SOFT_STOP_BIT];
    assign start_req = soft_start || (timer_start_enable && timer2_trigger);
    assign stop_req = soft_stop || (timer_stop_enable && timer3_trigger);

    // Sampling sequencer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= rpd_pkg::RPD_IDLE;
            stop_pending_reg <= 1'b0;
        end else if (!detector_enable) begin
            state_reg <= rpd_pkg::RPD_IDLE;
            stop_pending_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                rpd_pkg::RPD_IDLE: begin
                    stop_pending_reg <= 1'b0;
                    if (start_req) begin
                        state_reg <= rpd_pkg::RPD_RUN;
                    end
                end
                rpd_pkg::RPD_RUN: begin
                    if (fire && stop_pending_reg) begin
                        state_reg <= rpd_pkg::RPD_IDLE;
                        stop_pending_reg <= 1'b0;
                    end else if (stop_req) begin
                        stop_pending_reg <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= rpd_pkg::RPD_IDLE;
                    stop_pending_reg <= 1'b0;
                end
            endcase
        end
    end

    // Consecutive hit counter and ordinary-mode arming
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hit_cnt_reg <= 4'h0;
            armed_reg <= 1'b0;
        end else if (!running) begin
            hit_cnt_reg <= 4'h0;
            armed_reg <= 1'b0;
        end else if (fire) begin
            hit_cnt_reg <= 4'h0;
            armed_reg <= 1'b0;
        end else if (sample_ok) begin
            if (hit) begin
                hit_cnt_reg <= hit_cnt_reg + 4'h1;
            end else begin
                hit_cnt_reg <= 4'h0;
                armed_reg <= armed_reg || !match;
            end
        end else if (per_pulse_recount && sample_mode == rpd_pkg::MODE_PWM_ON && pwm_fall) begin
            hit_cnt_reg <= 4'h0;
        end
    end

    // Start pattern is taken only when leaving idle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            captured_input_pattern_reg <= 3'h0;
        end else if (detector_enable && !running && start_req) begin
            captured_input_pattern_reg <= live_in;
        end
    end

    // Detection outputs and PWM edge results
    always_ff @(posedge clk) begin
        if (!resetn) begin
            position_interrupt <= 1'b0;
            position_detected <= 1'b0;
            pwm_edge_result_reg <= 2'h0;
        end else begin
            position_interrupt <= fire;
            if (fire) begin
                position_detected <= 1'b1;
            end else if (!running || start_req) begin
                position_detected <= 1'b0;
            end
            if (!running && start_req) begin
                pwm_edge_result_reg <= 2'h0;
            end else begin
                if (pwm_fall) begin
                    pwm_edge_result_reg[1] <= position_detected || fire;
                end
                if (pwm_rise) begin
                    pwm_edge_result_reg[0] <= position_detected || fire;
                end
            end
        end
    end

    // AXI4-Lite write side, address and data in either order
    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rpd_pkg::RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready <= !w_held_reg && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_reg <= rpd_pkg::PATTERN_OFS && awaddr_reg[1:0] == 2'h0) ?
                               rpd_pkg::RESP_OKAY : rpd_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register stores; stop and start bits are strobes only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sampling_setup_reg <= rpd_pkg::SETUP_RST;
            control_reg <= rpd_pkg::CONTROL_RST;
            sampling_delay_reg <= rpd_pkg::DELAY_RST;
            motor_output_pattern_reg <= rpd_pkg::PATTERN_RST;
        end else if (wr_do && wstrb0_reg) begin
            unique case (awaddr_reg)
                rpd_pkg::SETUP_OFS: sampling_setup_reg <= wdata_reg[7:0];
                rpd_pkg::CONTROL_OFS: control_reg <= wdata_reg[5:0];
                rpd_pkg::DELAY_OFS: sampling_delay_reg <= wdata_reg[6:0];
                rpd_pkg::PATTERN_OFS: motor_output_pattern_reg <= wdata_reg[2:0];
                default: ;
            endcase
        end
    end

    // AXI4-Lite read side, one cycle after acceptance
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rpd_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rpd_pkg::RESP_OKAY;
                unique case (s_axi_araddr)
                    rpd_pkg::STATUS_OFS: s_axi_rdata <= {24'h0, 2'h0, pwm_edge_result_reg,
                                                         running, captured_input_pattern_reg};
                    rpd_pkg::SETUP_OFS: s_axi_rdata <= {24'h0, sampling_setup_reg};
                    rpd_pkg::CONTROL_OFS: s_axi_rdata <= {26'h0, control_reg};
                    rpd_pkg::DELAY_OFS: s_axi_rdata <= {25'h0, sampling_delay_reg};
                    rpd_pkg::PATTERN_OFS: s_axi_rdata <= {29'h0, motor_output_pattern_reg};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= rpd_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    property p_intr_follows_fire;
        @(posedge clk) disable iff (!resetn) fire |=> position_interrupt && position_detected;
    endproperty
    a_intr_follows_fire: assert property (p_intr_follows_fire) else $error("no interrupt");

    property p_disable_idles;
        @(posedge clk) disable iff (!resetn) !detector_enable |=> !running;
    endproperty
    a_disable_idles: assert property (p_disable_idles) else $error("runs while off");

    property p_soft_start;
        @(posedge clk) disable iff (!resetn)
            (soft_start && detector_enable && !running) |=> running;
    endproperty
    a_soft_start: assert property (p_soft_start) else $error("start ignored");

    property p_stop_finish;
        @(posedge clk) disable iff (!resetn)
            (fire && stop_pending_reg && detector_enable) |=> !running ##1 !position_interrupt;
    endproperty
    a_stop_finish: assert property (p_stop_finish) else $error("no stop at hit");

    property p_stop_pending;
        @(posedge clk) disable iff (!resetn)
            (running && stop_req && !fire && detector_enable) |=> stop_pending_reg && running;
    endproperty
    a_stop_pending: assert property (p_stop_pending) else $error("stop lost");

    property p_capture;
        @(posedge clk) disable iff (!resetn)
            (detector_enable && !running && start_req) |=>
                captured_input_pattern_reg == $past(live_in);
    endproperty
    a_capture: assert property (p_capture) else $error("bad capture");

    property p_period4;
        @(posedge clk) disable iff (!resetn)
            (strobe && period_sel == 2'h0) |->
                !$past(strobe) && !$past(strobe, 2) && !$past(strobe, 3);
    endproperty
    a_period4: assert property (p_period4) else $error("strobe too close");

    property p_blanking;
        @(posedge clk) disable iff (!resetn)
            (sample_mode == rpd_pkg::MODE_PWM_ON && delay_cnt_reg != 7'h00) |-> !window;
    endproperty
    a_blanking: assert property (p_blanking) else $error("sampled in delay");

    property p_recount;
        @(posedge clk) disable iff (!resetn)
            (per_pulse_recount && sample_mode == rpd_pkg::MODE_PWM_ON && pwm_fall)
                |=> hit_cnt_reg == 4'h0;
    endproperty
    a_recount: assert property (p_recount) else $error("count kept");

    property p_one_pin;
        @(posedge clk) disable iff (!resetn)
            one_pin |-> match == (eff_in[0] == motor_output_pattern_reg[0]);
    endproperty
    a_one_pin: assert property (p_one_pin) else $error("v w compared");
endmodule : rpd_top
`default_nettype wire

// >>> rtl/rpd_pkg.sv
// Constants for the rotor position detector
`default_nettype none
package rpd_pkg;
    // Register byte offsets
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] SETUP_OFS = 8'h04;
    localparam logic [7:0] CONTROL_OFS = 8'h08;
    localparam logic [7:0] DELAY_OFS = 8'h0c;
    localparam logic [7:0] PATTERN_OFS = 8'h10;
    // Reset values
    localparam logic [7:0] SETUP_RST = 8'h00;
    localparam logic [5:0] CONTROL_RST = 6'h00;
    localparam logic [6:0] DELAY_RST = 7'h00;
    localparam logic [2:0] PATTERN_RST = 3'h0;
    // Status field positions
    localparam int ST_EDGE_FALL_BIT = 5;
    localparam int ST_EDGE_RISE_BIT = 4;
    localparam int ST_ACTIVE_BIT = 3;
    // Setup field positions
    localparam int SU_PERIOD_LSB = 6;
    localparam int SU_MODE_LSB = 4;
    localparam int SU_COUNT_LSB = 0;
    // Control field positions
    localparam int CT_SOFT_STOP_BIT = 7;
    localparam int CT_SOFT_START_BIT = 6;
    localparam int CT_TSTOP_EN_BIT = 5;
    localparam int CT_TSTART_EN_BIT = 4;
    localparam int CT_PIN_COUNT_BIT = 3;
    localparam int CT_RECOUNT_BIT = 2;
    localparam int CT_MISMATCH_BIT = 1;
    localparam int CT_ENABLE_BIT = 0;
    // Sampling modes
    localparam logic [1:0] MODE_PWM_ON = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0] MODE_LOWER = 2'h2;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        RPD_IDLE = 2'b01,
        RPD_RUN = 2'b10
    } rpd_state_e;
endpackage : rpd_pkg
`default_nettype wire

// >>> tb/rpd_sensor.sv
// Behavioural model of the position sensors feeding the detector
`default_nettype none
module rpd_sensor (
    input wire logic clk,
    input wire logic [2:0] level,
    input wire logic [2:0] as_output,
    output logic phase_u_input,
    output logic phase_v_input,
    output logic phase_w_input
);
    timeunit 1ns;
    timeprecision 1ps;
    // Registered so inputs change only after an edge
    always_ff @(posedge clk) begin
        // Pins set as outputs read 0 at the detector
        {phase_w_input, phase_v_input, phase_u_input} <= level & ~as_output;
    end
endmodule : rpd_sensor
`default_nettype wire

// >>> tb/rotor_position_detector_test.sv
// Self-checking bench for the rotor position detector
`default_nettype none
module rotor_position_detector_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, awvalid, wvalid, arvalid, t2, t3;
    logic awready, wready, bvalid, arready, rvalid, det, irq, u, v, w;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic [2:0] lvl, pwm, mask, lo;
    int fails, n_tests, n;

    rpd_sensor sensor (.clk(clk), .level(lvl), .as_output(mask),
        .phase_u_input(u), .phase_v_input(v), .phase_w_input(w));

    rpd_top DUT (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .phase_u_input(u), .phase_v_input(v), .phase_w_input(w), .pwm_phase_on(pwm),
        .lower_phase_on(lo), .timer2_trigger(t2), .timer3_trigger(t3),
        .position_detected(det), .position_interrupt(irq));

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        rs = bresp;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rd = rdata;
        rs = rresp;
    endtask : rdr

    task automatic wait_irq(input int lim);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq !== 1'h1 && n < lim);
    endtask : wait_irq

    task automatic active_is(input logic e);
        rdr(rpd_pkg::STATUS_OFS);
        chk("sampling active", e, rd[rpd_pkg::ST_ACTIVE_BIT]);
    endtask : active_is

    task automatic t_regs;
        rdr(rpd_pkg::SETUP_OFS);
        chk("setup reset", 32'h0, rd);
        rdr(rpd_pkg::DELAY_OFS);
        chk("delay reset", 32'h0, rd);
        wr(rpd_pkg::SETUP_OFS, 8'hb7);
        rdr(rpd_pkg::SETUP_OFS);
        chk("setup readback", 32'hb7, rd);
        // Enable low, so the start strobe must not launch sampling
        wr(rpd_pkg::CONTROL_OFS, 8'hfc);
        active_is(1'h0);
        rdr(rpd_pkg::CONTROL_OFS);
        chk("control strobes", 32'h3c, rd);
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        rdr(8'h14);
        chk("unmapped resp", rpd_pkg::RESP_SLVERR, rs);
        wr(8'h14, 8'h00);
        chk("unmapped wr resp", rpd_pkg::RESP_SLVERR, rs);
        $display("test regs done");
    endtask : t_regs

    task automatic t_ordinary;
        lvl <= 3'h2;
        wr(rpd_pkg::SETUP_OFS, 8'hd8);
        wr(rpd_pkg::PATTERN_OFS, 8'h05);
        wr(rpd_pkg::CONTROL_OFS, 8'h01);
        wr(rpd_pkg::CONTROL_OFS, 8'h41);
        active_is(1'h1);
        repeat (70) @(posedge clk);
        chk("no early detect", 1'h0, det);
        lvl <= 3'h5;
        wait_irq(400);
        // Eight samples at one per 32 clocks
        chk("match delay", 1'h1, n >= 224 && n <= 260);
        chk("detected", 1'h1, det);
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        active_is(1'h0);
        $display("test ordinary done");
    endtask : t_ordinary

    task automatic t_mismatch;
        lvl <= 3'h3;
        wr(rpd_pkg::SETUP_OFS, 8'h12);
        wr(rpd_pkg::CONTROL_OFS, 8'h03);
        wr(rpd_pkg::CONTROL_OFS, 8'h43);
        rdr(rpd_pkg::STATUS_OFS);
        chk("start pattern", 3'h3, rd[2:0]);
        lvl <= 3'h7;
        wait_irq(40);
        chk("change delay", 1'h1, n >= 4 && n <= 14);
        chk("detected", 1'h1, det);
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        $display("test mismatch done");
    endtask : t_mismatch

    task automatic t_stop;
        lvl <= 3'h0;
        wr(rpd_pkg::SETUP_OFS, 8'h11);
        wr(rpd_pkg::PATTERN_OFS, 8'h01);
        wr(rpd_pkg::CONTROL_OFS, 8'h09);
        wr(rpd_pkg::CONTROL_OFS, 8'h49);
        repeat (10) @(posedge clk);
        wr(rpd_pkg::CONTROL_OFS, 8'h89);
        active_is(1'h1);
        // V and W disagree with the pattern, U alone decides
        lvl <= 3'h7;
        wait_irq(40);
        chk("u only detect", 1'h1, irq);
        repeat (2) @(posedge clk);
        active_is(1'h0);
        $display("test stop done");
    endtask : t_stop

    task automatic t_timer;
        wr(rpd_pkg::CONTROL_OFS, 8'h31);
        t2 <= 1'h1;
        @(posedge clk);
        t2 <= 1'h0;
        repeat (4) @(posedge clk);
        active_is(1'h1);
        t3 <= 1'h1;
        @(posedge clk);
        t3 <= 1'h0;
        repeat (10) @(posedge clk);
        active_is(1'h1);
        lvl <= 3'h1;
        wait_irq(40);
        chk("timer stop detect", 1'h1, irq);
        repeat (2) @(posedge clk);
        active_is(1'h0);
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        $display("test timer done");
    endtask : t_timer

    task automatic t_pwm;
        lvl <= 3'h0;
        wr(rpd_pkg::SETUP_OFS, 8'h01);
        wr(rpd_pkg::DELAY_OFS, 8'h10);
        wr(rpd_pkg::PATTERN_OFS, 8'h02);
        wr(rpd_pkg::CONTROL_OFS, 8'h01);
        wr(rpd_pkg::CONTROL_OFS, 8'h41);
        pwm <= 3'h1;
        repeat (30) @(posedge clk);
        pwm <= 3'h0;
        lvl <= 3'h2;
        repeat (40) @(posedge clk);
        chk("off time ignored", 1'h0, det);
        pwm <= 3'h4;
        wait_irq(60);
        chk("holdoff delay", 1'h1, n >= 16 && n <= 26);
        repeat (3) @(posedge clk);
        pwm <= 3'h0;
        repeat (3) @(posedge clk);
        rdr(rpd_pkg::STATUS_OFS);
        chk("falling edge result", 1'h1, rd[rpd_pkg::ST_EDGE_FALL_BIT]);
        pwm <= 3'h4;
        repeat (3) @(posedge clk);
        rdr(rpd_pkg::STATUS_OFS);
        chk("rising edge result", 1'h1, rd[rpd_pkg::ST_EDGE_RISE_BIT]);
        pwm <= 3'h0;
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        $display("test pwm done");
    endtask : t_pwm

    // Six-clock pulses hold at most two samples at the fastest period
    task automatic pulses(input int k);
        repeat (k) begin
            pwm <= 3'h0;
            repeat (6) @(posedge clk);
            pwm <= 3'h2;
            repeat (6) @(posedge clk);
        end
        pwm <= 3'h0;
    endtask : pulses

    task automatic t_recount;
        lvl <= 3'h0;
        wr(rpd_pkg::SETUP_OFS, 8'h03);
        wr(rpd_pkg::DELAY_OFS, 8'h00);
        wr(rpd_pkg::PATTERN_OFS, 8'h04);
        wr(rpd_pkg::CONTROL_OFS, 8'h05);
        wr(rpd_pkg::CONTROL_OFS, 8'h45);
        pwm <= 3'h2;
        repeat (12) @(posedge clk);
        lvl <= 3'h4;
        pulses(8);
        chk("recount per pulse", 1'h0, det);
        wr(rpd_pkg::CONTROL_OFS, 8'h01);
        pulses(4);
        chk("count across pulses", 1'h1, det);
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        $display("test recount done");
    endtask : t_recount

    task automatic t_lower;
        lvl <= 3'h0;
        lo <= 3'h1;
        wr(rpd_pkg::SETUP_OFS, 8'h21);
        wr(rpd_pkg::PATTERN_OFS, 8'h05);
        wr(rpd_pkg::CONTROL_OFS, 8'h01);
        wr(rpd_pkg::CONTROL_OFS, 8'h41);
        repeat (12) @(posedge clk);
        lvl <= 3'h1;
        repeat (12) @(posedge clk);
        chk("w lane not yet sampled", 1'h0, det);
        // U keeps its held 1; V level high but pin set as output
        mask <= 3'h2;
        lvl <= 3'h6;
        lo <= 3'h6;
        wait_irq(40);
        chk("held u with live w", 1'h1, irq);
        chk("masked v pin", 1'h1, det);
        wr(rpd_pkg::CONTROL_OFS, 8'h00);
        lo <= 3'h0;
        mask <= 3'h0;
        $display("test lower done");
    endtask : t_lower

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Whole run needs about a thousand clocks
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        wrap_up();
    end

    initial begin
        {resetn, awvalid, wvalid, arvalid, t2, t3} = 6'h0;
        {awaddr, araddr, wdata} = 48'h0;
        {lvl, pwm, mask, lo} = 12'h0;
        fails = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        t_regs();
        t_ordinary();
        t_mismatch();
        t_stop();
        t_timer();
        t_pwm();
        t_recount();
        t_lower();
        wrap_up();
    end
endmodule : rotor_position_detector_test
`default_nettype wire
